// file: inc/exc_pkg.sv
/*
 Constants, register map and state encoding for the exception and
 low-power controller. Assumes a single 50 MHz clock that also stands
 in for the crystal reference clock during stop recovery.
*/
// Function
// [RULE1] Hardware interrupts start only after the current instruction completes.
// [RULE2] At a boundary take an interrupt only if mask clear and enabled.
// [RULE3] A latched interrupt cannot be displaced until it is serviced.
// [RULE4] Arbitrate at entry and hold a constant vector select for the CPU.
// [RULE5] Highest pending first; leftovers serviced before the next main-line instruction.
// [RULE6] Fixed order of twenty sources; reset and software interrupt rank above.
// [RULE7] Entry stacks registers and sets the mask; return unstacks them.
// [RULE8] Entry never stacks the high index register.
// [RULE9] Software interrupt instruction is taken regardless of the mask bit.
// [RULE10] Software interrupt stacks PC; hardware interrupt stacks PC minus one.
// [RULE11] First status register: flags 1-6 in bits 7-2, bits 1-0 zero.
// [RULE12] Second status register: flags 14 down to 7 in all eight bits.
// [RULE13] Third status register: bits 7-6 zero, flags 20 to 15 below.
// [RULE14] Any reset source wins at top priority without arbitration.
// [RULE15] Break request forces the CPU to the software interrupt vector.
// [RULE16] In break with clear enable off, peripheral flags resist clearing.
// [RULE17] Two-step clears stay blocked in break; second step works afterwards.
// [RULE18] Wait or stop clears the mask bit and halts CPU clocking.
// [RULE19] Wait stops CPU clock only; enabled interrupt wakes, stacking next cycle.
// [RULE20] Reset or emulation break ends wait; break sets wait-exit flag.
// [RULE21] Watchdog disable option zero keeps the watchdog running, also in wait.
// [RULE22] Stop gates both clocks; system counter held in reset until recovery.
// [RULE23] Stop recovery lasts 4096 cycles, or 32 with short option set.
// [RULE24] Stop ends on enabled interrupt or reset; stacking after recovery.
// [RULE25] Status registers ignore writes, mirror live requests, reads have no effect.
package exc_pkg;
   // ==========================================================
   // Sources and vectors
   localparam int           NUM_SRC      = 20;
   localparam int           VEC_W        = 5;
   localparam logic [4:0]   VEC_SWI      = 5'h00;

   // ==========================================================
   // Register map, byte offsets on the bus
   localparam logic [7:0]   OFS_PEND1    = 8'h00;
   localparam logic [7:0]   OFS_PEND2    = 8'h04;
   localparam logic [7:0]   OFS_PEND3    = 8'h08;
   localparam logic [7:0]   OFS_BRK_STAT = 8'h0C;
   localparam logic [7:0]   OFS_BRK_CTRL = 8'h10;
   localparam int           BIT_WAIT_EXIT = 1;
   localparam int           BIT_BREAK_CLEAR_ENABLE     = 7;
   localparam logic         RST_WAIT_EXIT = 1'b0;
   localparam logic         RST_BREAK_CLEAR_ENABLE     = 1'b0;

   // ==========================================================
   // Stop recovery timing in crystal clock cycles
   localparam int           CLK_NS       = 20;
   localparam int           XTAL_NS      = 20;
   localparam int           STOP_REC_LONG  = 4096;
   localparam int           STOP_REC_SHORT = 32;
   localparam int           REC_LONG_CYC =
      (STOP_REC_LONG * XTAL_NS + CLK_NS - 1) / CLK_NS;
   localparam int           REC_SHORT_CYC =
      (STOP_REC_SHORT * XTAL_NS + CLK_NS - 1) / CLK_NS;
   localparam int           CNT_W        = 13;

   // ==========================================================
   // Sequencer states
   typedef enum logic [3:0] {
      ST_RUN     = 4'b0001,
      ST_WAIT    = 4'b0010,
      ST_STOP    = 4'b0100,
      ST_RECOVER = 4'b1000
   } state_t;
endpackage

// file: rtl/stop_recovery_timer.sv
/*
 System counter used to time stop recovery.
 Assumes clear is asserted from the stop instruction until recovery
 should start; the counter free-runs at all other times.
*/
`timescale 1ns/1ps
module stop_recovery_timer #(
   parameter int LONG_CYCLES  = exc_pkg::REC_LONG_CYC,
   parameter int SHORT_CYCLES = exc_pkg::REC_SHORT_CYC
) (
   // Clock and reset
   input  wire logic clk_sys,
   input  wire logic rstn,
   // Control
   input  wire logic hold_clr,
   input  wire logic short_sel,
   // Status
   output logic      done
);
   localparam logic [exc_pkg::CNT_W-1:0] LIM_LONG  =
      exc_pkg::CNT_W'(LONG_CYCLES - 1);
   localparam logic [exc_pkg::CNT_W-1:0] LIM_SHORT =
      exc_pkg::CNT_W'(SHORT_CYCLES - 1);

   logic [exc_pkg::CNT_W-1:0] cnt_ff;

   // ==========================================================
   // Counter, cleared while stop holds it
   always_ff @(posedge clk_sys) begin
      if (!rstn || hold_clr) begin // [RULE22]
         cnt_ff <= '0;
      end else begin
         cnt_ff <= cnt_ff + 1'b1;
      end
   end

   // Terminal count selects the long or short delay
   assign done = !hold_clr &&
                 (cnt_ff == (short_sel ? LIM_SHORT : LIM_LONG)); // [RULE23]
endmodule

// file: rtl/exception_and_low_power_control.sv
/*
 Exception control and low-power sequencing: interrupt latch and
 arbitration, software interrupt and break redirection, break flag
 protection, wait and stop sequencing, and an AHB-Lite register slave.
 Assumes the CPU pulses insn_done at each instruction boundary and
 vector_ack when it fetches the latched vector, and that all inputs
 are synchronous to clk_sys.
*/
// Chosen here: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module exception_and_low_power_control #(
   parameter int NUM_SRC      = exc_pkg::NUM_SRC,
   parameter int REC_LONG     = exc_pkg::REC_LONG_CYC,
   parameter int REC_SHORT    = exc_pkg::REC_SHORT_CYC
) (
   // Clock and reset
   input  wire logic               clk_sys,
   input  wire logic               rstn,
   // AHB-Lite slave
   input  wire logic               hsel,
   input  wire logic [31:0]        haddr,
   input  wire logic [1:0]         htrans,
   input  wire logic               hwrite,
   input  wire logic [2:0]         hsize,
   input  wire logic [31:0]        hwdata,
   input  wire logic               hready,
   output logic                    hreadyout,
   output logic                    hresp,
   output logic [31:0]             hrdata,
   // Interrupt sources
   input  wire logic [NUM_SRC-1:0] irq_req,
   input  wire logic [NUM_SRC-1:0] irq_en,
   // CPU side
   input  wire logic               insn_done,
   input  wire logic               ccr_imask,
   input  wire logic               swi_exec,
   input  wire logic               wait_exec,
   input  wire logic               stop_exec,
   input  wire logic               rti_exec,
   input  wire logic               vector_ack,
   output logic                    int_request,
   output logic [4:0]              vector_sel,
   output logic                    push_pc_minus1,
   output logic                    stack_index_high,
   output logic                    set_imask,
   output logic                    clr_imask,
   // Reset, break and options
   input  wire logic               reset_req,
   input  wire logic               break_req,
   input  wire logic               emul_mode,
   input  wire logic               watchdog_disable_option,
   input  wire logic               short_stop_recovery_option,
   // Clock gating and system status
   output logic                    cpu_clk_en,
   output logic                    periph_clk_en,
   output logic                    watchdog_enable,
   output logic                    in_break,
   output logic                    flag_clear_allow
);
   // ==========================================================
   // Declarations
   exc_pkg::state_t     state_ff;
   exc_pkg::state_t     nxt_state;
   logic                lat_valid_ff;
   logic [4:0]          lat_idx_ff;
   logic                lat_brk_ff;
   logic                hw_minus1_ff;
   logic                brk_mode_ff;
   logic                wait_exit_ff;
   logic                break_clear_enable_ff;
   logic [NUM_SRC-1:0]  pend;
   logic                hw_hit;
   logic [4:0]          hw_idx;
   logic                grab;
   logic                grab_soft;
   logic                grab_brk;
   logic                rec_done;
   logic                hold_clr;
   logic                wr_pend_ff;
   logic [7:0]          wr_ofs_ff;
   logic                addr_ok;
   logic [7:0]          rd_mux;
   logic [31:0]         hrdata_ff;

   // Highest priority is the lowest index; result is flag number
   function automatic logic [4:0] prio(input logic [NUM_SRC-1:0] v);
      logic [4:0] r;
      r = 5'h00;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = 5'(i + 1);
         end
      end
      return r;
   endfunction

   assign pend   = irq_req & irq_en;
   assign hw_hit = |pend;
   assign hw_idx = prio(pend); // [RULE6]

   // ==========================================================
   // Wake and entry decision per state
   always_comb begin
      nxt_state = state_ff;
      grab      = 1'b0;
      grab_soft = 1'b0;
      grab_brk  = 1'b0;
      case (state_ff)
         exc_pkg::ST_RUN: begin
            // Only at a boundary, never mid-instruction
            if (insn_done) begin // [RULE1]
               if (break_req) begin // [RULE15]
                  grab      = 1'b1;
                  grab_soft = 1'b1;
                  grab_brk  = 1'b1;
               end else if (swi_exec) begin // [RULE9]
                  grab      = 1'b1;
                  grab_soft = 1'b1;
               end else if (hw_hit && !ccr_imask) begin // [RULE2] [RULE5]
                  grab      = 1'b1;
               end else if (wait_exec) begin
                  nxt_state = exc_pkg::ST_WAIT; // [RULE18]
               end else if (stop_exec) begin
                  nxt_state = exc_pkg::ST_STOP; // [RULE18]
               end
            end
         end
         exc_pkg::ST_WAIT: begin
            // Mask was cleared on entry, so it is not consulted here
            if (break_req && emul_mode) begin // [RULE20]
               grab      = 1'b1;
               grab_soft = 1'b1;
               grab_brk  = 1'b1;
               nxt_state = exc_pkg::ST_RUN;
            end else if (hw_hit) begin // [RULE19]
               grab      = 1'b1;
               nxt_state = exc_pkg::ST_RUN;
            end
         end
         exc_pkg::ST_STOP: begin
            if (hw_hit || break_req) begin // [RULE24]
               nxt_state = exc_pkg::ST_RECOVER;
            end
         end
         exc_pkg::ST_RECOVER: begin
            // Stacking waits for the full recovery delay
            if (rec_done) begin // [RULE24]
               nxt_state = exc_pkg::ST_RUN;
               if (break_req) begin
                  grab      = 1'b1;
                  grab_soft = 1'b1;
                  grab_brk  = 1'b1;
               end else if (hw_hit) begin
                  grab      = 1'b1;
               end
            end
         end
         default: begin
            nxt_state = exc_pkg::ST_RUN;
         end
      endcase
   end

   // ==========================================================
   // Sequencer state
   always_ff @(posedge clk_sys) begin
      if (!rstn || reset_req) begin // [RULE14]
         state_ff <= exc_pkg::ST_RUN;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // ==========================================================
   // Interrupt latch; a held entry cannot be displaced
   always_ff @(posedge clk_sys) begin
      if (!rstn || reset_req) begin // [RULE14]
         lat_valid_ff <= 1'b0;
         lat_idx_ff   <= exc_pkg::VEC_SWI;
         lat_brk_ff   <= 1'b0;
         hw_minus1_ff <= 1'b0;
      end else if (lat_valid_ff) begin
         if (vector_ack) begin // [RULE3]
            lat_valid_ff <= 1'b0;
         end
      end else if (grab) begin
         lat_valid_ff <= 1'b1;
         lat_idx_ff   <= grab_soft ? exc_pkg::VEC_SWI : hw_idx; // [RULE4]
         lat_brk_ff   <= grab_brk;
         hw_minus1_ff <= !grab_soft; // [RULE10]
      end
   end

   assign int_request      = lat_valid_ff;
   assign vector_sel       = lat_idx_ff; // [RULE4]
   assign push_pc_minus1   = hw_minus1_ff;
   // Frame never includes the high index byte
   assign stack_index_high = 1'b0; // [RULE8]
   assign set_imask        = lat_valid_ff && vector_ack; // [RULE7]
   assign clr_imask        = (state_ff == exc_pkg::ST_RUN) && insn_done &&
                             !grab && (wait_exec || stop_exec) &&
                             !reset_req; // [RULE18]

   // ==========================================================
   // Break mode tracking and flag protection
   always_ff @(posedge clk_sys) begin
      if (!rstn || reset_req) begin
         brk_mode_ff <= 1'b0;
      end else if (lat_valid_ff && vector_ack && lat_brk_ff) begin
         brk_mode_ff <= 1'b1;
      end else if (rti_exec) begin // [RULE7]
         brk_mode_ff <= 1'b0;
      end
   end

   assign in_break = brk_mode_ff;
   // Peripherals keep any first step armed; only the clear is gated
   assign flag_clear_allow = !brk_mode_ff || break_clear_enable_ff; // [RULE16] [RULE17]

   // ==========================================================
   // Clock gating, watchdog and system counter control
   assign cpu_clk_en      = (state_ff == exc_pkg::ST_RUN); // [RULE19]
   assign periph_clk_en   = (state_ff == exc_pkg::ST_RUN) ||
                            (state_ff == exc_pkg::ST_WAIT); // [RULE22]
   assign watchdog_enable = !watchdog_disable_option; // [RULE21]
   assign hold_clr        = (state_ff == exc_pkg::ST_STOP) ||
                            (nxt_state == exc_pkg::ST_STOP); // [RULE22]

   stop_recovery_timer #(
      .LONG_CYCLES  (REC_LONG),
      .SHORT_CYCLES (REC_SHORT)
   ) u_rec (
      .clk_sys   (clk_sys),
      .rstn      (rstn),
      .hold_clr  (hold_clr),
      .short_sel (short_stop_recovery_option),
      .done      (rec_done)
   );

   // ==========================================================
   // AHB-Lite slave, zero wait states
   assign addr_ok = hsel && htrans[1] && hready;

   always_comb begin
      case (haddr[7:0])
         exc_pkg::OFS_PEND1:
            rd_mux = {irq_req[5:0], 2'b00}; // [RULE11] [RULE25]
         exc_pkg::OFS_PEND2:
            rd_mux = irq_req[13:6]; // [RULE12] [RULE25]
         exc_pkg::OFS_PEND3:
            rd_mux = {2'b00, irq_req[19:14]}; // [RULE13] [RULE25]
         exc_pkg::OFS_BRK_STAT: begin
            rd_mux = 8'h00;
            rd_mux[exc_pkg::BIT_WAIT_EXIT] = wait_exit_ff;
         end
         exc_pkg::OFS_BRK_CTRL: begin
            rd_mux = 8'h00;
            rd_mux[exc_pkg::BIT_BREAK_CLEAR_ENABLE] = break_clear_enable_ff;
         end
         default:
            rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         hrdata_ff  <= 32'h0000_0000;
         wr_pend_ff <= 1'b0;
         wr_ofs_ff  <= 8'h00;
      end else begin
         wr_pend_ff <= addr_ok && hwrite;
         if (addr_ok) begin
            wr_ofs_ff <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            hrdata_ff <= {24'h00_0000, rd_mux};
         end
      end
   end

   assign hrdata    = hrdata_ff;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Control bit; pending flag writes fall through and are dropped
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         break_clear_enable_ff <= exc_pkg::RST_BREAK_CLEAR_ENABLE;
      end else if (wr_pend_ff && wr_ofs_ff == exc_pkg::OFS_BRK_CTRL) begin
         break_clear_enable_ff <= hwdata[exc_pkg::BIT_BREAK_CLEAR_ENABLE];
      end
   end

   // Wait-exit flag: set beats a same-cycle clear by writing zero
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         wait_exit_ff <= exc_pkg::RST_WAIT_EXIT;
      end else if (state_ff == exc_pkg::ST_WAIT && break_req &&
                   emul_mode && !reset_req) begin // [RULE20]
         wait_exit_ff <= 1'b1;
      end else if (wr_pend_ff && wr_ofs_ff == exc_pkg::OFS_BRK_STAT &&
                   !hwdata[exc_pkg::BIT_WAIT_EXIT]) begin
         wait_exit_ff <= 1'b0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rstn);

   property p_boundary;
      $rose(lat_valid_ff) |->
         $past(insn_done) || $past(state_ff != exc_pkg::ST_RUN);
   endproperty
   a_boundary: assert property (p_boundary) // [RULE1]
      else $error("interrupt latched mid-instruction");

   property p_take;
      (state_ff == exc_pkg::ST_RUN) && insn_done && hw_hit && !ccr_imask &&
      !lat_valid_ff && !reset_req |=> lat_valid_ff;
   endproperty
   a_take: assert property (p_take) // [RULE2]
      else $error("enabled unmasked interrupt not taken");

   property p_hold;
      lat_valid_ff && !vector_ack && !reset_req |=>
         lat_valid_ff && $stable(vector_sel);
   endproperty
   a_hold: assert property (p_hold) // [RULE3]
      else $error("latched interrupt displaced");

   property p_prio;
      $rose(lat_valid_ff) && !$past(grab_soft) |->
         vector_sel == prio($past(pend));
   endproperty
   a_prio: assert property (p_prio) // [RULE6]
      else $error("wrong priority winner");

   property p_swi;
      (state_ff == exc_pkg::ST_RUN) && insn_done && swi_exec && ccr_imask &&
      !lat_valid_ff && !reset_req |=>
         lat_valid_ff && vector_sel == exc_pkg::VEC_SWI && !push_pc_minus1;
   endproperty
   a_swi: assert property (p_swi) // [RULE9]
      else $error("software interrupt masked");

   property p_pc;
      lat_valid_ff |-> push_pc_minus1 == (vector_sel != exc_pkg::VEC_SWI);
   endproperty
   a_pc: assert property (p_pc) // [RULE10]
      else $error("wrong stacked return address kind");

   property p_wait_wake;
      (state_ff == exc_pkg::ST_WAIT) && hw_hit && !break_req && !reset_req
         |=> cpu_clk_en && lat_valid_ff;
   endproperty
   a_wait_wake: assert property (p_wait_wake) // [RULE19]
      else $error("wait not woken in one cycle");

   property p_stop_gate;
      (state_ff == exc_pkg::ST_STOP) |-> !cpu_clk_en && !periph_clk_en;
   endproperty
   a_stop_gate: assert property (p_stop_gate) // [RULE22]
      else $error("clock running in stop");

   property p_protect;
      brk_mode_ff && !break_clear_enable_ff |-> !flag_clear_allow;
   endproperty
   a_protect: assert property (p_protect) // [RULE16]
      else $error("flag clear allowed in protected break");

   property p_reset;
      reset_req |=> !lat_valid_ff && state_ff == exc_pkg::ST_RUN;
   endproperty
   a_reset: assert property (p_reset) // [RULE14]
      else $error("reset did not override");

   c_hw_int: cover property ($rose(lat_valid_ff) && push_pc_minus1);
   c_wait_wake: cover property (state_ff == exc_pkg::ST_WAIT ##1
                                state_ff == exc_pkg::ST_RUN);
   c_stop_rec: cover property (state_ff == exc_pkg::ST_RECOVER && rec_done);
   c_break: cover property ($rose(brk_mode_ff));
endmodule

// file: testbench/cpu_model.sv
/*
 CPU stand-in for the entry handshake: fetches the latched vector
 a set number of cycles after the request appears.
 Assumes int_request stays up until the acknowledge is sampled.
*/
`timescale 1ns/1ps
module cpu_model (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       rstn,
   // Entry handshake
   input  wire logic       int_request,
   input  wire logic [7:0] ack_delay,
   output logic            vector_ack
);
   logic [7:0] wait_ff;

   // ====================
   // Stacking then vector fetch
   always_ff @(posedge clk_sys) begin
      if (!rstn || vector_ack || !int_request) begin
         wait_ff    <= 8'h00;
         vector_ack <= 1'b0;
      end else if (wait_ff == ack_delay) begin
         vector_ack <= 1'b1;
      end else begin
         wait_ff <= wait_ff + 8'h01;
      end
   end
endmodule

// file: testbench/tb_top.sv
/*
 Self-checking bench: AHB-Lite register tasks and CPU boundary
 pulses. Assumes the CPU model acknowledges each entry.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
   errors++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module tb_top;
   localparam int NL = 64;
   localparam int NS = 8;
   logic        clk_sys, rstn, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [19:0] irq_req, irq_en, pat;
   logic        insn_done, ccr_imask, swi_exec, wait_exec, stop_exec;
   logic        rti_exec, vector_ack, int_request, push_pc_minus1;
   logic        stack_index_high, set_imask, clr_imask, reset_req;
   logic        break_req, emul_mode, wdo, sso, cpu_clk_en, last_clr;
   logic        periph_clk_en, watchdog_enable, in_break, flag_clear_allow;
   logic [4:0]  vector_sel;
   logic [7:0]  ack_delay;
   int          errors, samples_checked, n;

   assign hready = hreadyout;

   exception_and_low_power_control #(.REC_LONG(NL), .REC_SHORT(NS)) DUT (
      .clk_sys, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .irq_req, .irq_en, .insn_done,
      .ccr_imask, .swi_exec, .wait_exec, .stop_exec, .rti_exec,
      .vector_ack, .int_request, .vector_sel, .push_pc_minus1,
      .stack_index_high, .set_imask, .clr_imask, .reset_req, .break_req,
      .emul_mode, .watchdog_disable_option(wdo),
      .short_stop_recovery_option(sso), .cpu_clk_en, .periph_clk_en,
      .watchdog_enable, .in_break, .flag_clear_allow);

   cpu_model CPU (.clk_sys, .rstn, .int_request, .ack_delay, .vector_ack);

   // ====================
   // Tasks
   task finish_test();
      $display("Counts: %0d checked, %0d errors", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task rdy();
      n = 0;
      do begin
         @(posedge clk_sys);
         n++;
      end while (hready !== 1'b1 && n < 16);
      if (n >= 16) begin
         errors++;
         finish_test();
      end
   endtask

   task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h000000, a};
      rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      rdy();
      rd = hrdata;
      // Let the data-edge register updates settle before callers look
      #1;
   endtask

   // Kind bits: software interrupt, wait, stop
   task boundary(input logic [2:0] k);
      @(posedge clk_sys);
      insn_done <= 1'b1;
      {swi_exec, wait_exec, stop_exec} <= k;
      #1 last_clr = clr_imask;
      @(posedge clk_sys);
      insn_done <= 1'b0;
      {swi_exec, wait_exec, stop_exec} <= 3'h0;
      #1;
   endtask

   // Bounded wait for the entry request level, called off the edge
   task wait_req(input logic v, input int lim);
      n = 0;
      while (int_request !== v && n < lim) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      if (int_request !== v) begin
         errors++;
         $display("ERROR %0t: entry request timeout", $time);
         finish_test();
      end
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   // ====================
   // Main sequence
   initial begin
      {rstn, hsel, hwrite, insn_done, ccr_imask, swi_exec} = 6'h00;
      {wait_exec, stop_exec, rti_exec, reset_req, break_req} = 5'h00;
      {emul_mode, wdo, sso} = 3'h0;
      {haddr, hwdata} = 64'h0;
      {htrans, hsize} = 5'h02;
      irq_req = 20'h00000;
      irq_en = 20'h00000;
      ack_delay = 8'h14;
      errors = 0;
      samples_checked = 0;
      repeat (20) @(posedge clk_sys);
      rstn <= 1'b1;
      #1 `CHK(stack_index_high, 1'b0)
      for (int i = 0; i < 2; i++) begin
         pat = i ? 20'h5A3C0 : 20'hA5C3F;
         @(posedge clk_sys);
         irq_req <= pat;
         bus(1'b1, 8'h00, 32'h000000FF);
         bus(1'b0, 8'h00, 32'h0);
         `CHK(rd, {24'h0, pat[5:0], 2'h0})
         bus(1'b0, 8'h04, 32'h0);
         `CHK(rd, {24'h0, pat[13:6]})
         bus(1'b0, 8'h08, 32'h0);
         `CHK(rd, {26'h0, pat[19:14]})
      end
      bus(1'b0, 8'h20, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(hresp, 1'b0)
      $display("Status test done");
      @(posedge clk_sys);
      irq_req <= 20'h00208;
      irq_en <= 20'hFFFFF;
      ccr_imask <= 1'b1;
      boundary(3'h0);
      `CHK(int_request, 1'b0)
      @(posedge clk_sys);
      ccr_imask <= 1'b0;
      irq_en <= 20'hFFFF7;
      boundary(3'h0);
      `CHK(vector_sel, 5'h0A)
      wait_req(1'b0, 40);
      @(posedge clk_sys);
      irq_en <= 20'hFFFFF;
      boundary(3'h0);
      `CHK(vector_sel, 5'h04)
      `CHK(push_pc_minus1, 1'b1)
      @(posedge clk_sys);
      irq_req <= 20'h00209;
      boundary(3'h0);
      `CHK(vector_sel, 5'h04)
      wait_req(1'b0, 40);
      boundary(3'h0);
      `CHK(vector_sel, 5'h01)
      wait_req(1'b0, 40);
      $display("Priority test done");
      @(posedge clk_sys);
      ccr_imask <= 1'b1;
      irq_req <= 20'h00000;
      boundary(3'h4);
      `CHK(vector_sel, 5'h00)
      `CHK(push_pc_minus1, 1'b0)
      wait_req(1'b0, 40);
      @(posedge clk_sys);
      ccr_imask <= 1'b0;
      break_req <= 1'b1;
      boundary(3'h0);
      break_req <= 1'b0;
      `CHK(vector_sel, 5'h00)
      wait_req(1'b0, 40);
      `CHK(flag_clear_allow, 1'b0)
      `CHK(in_break, 1'b1)
      bus(1'b1, 8'h10, 32'h00000080);
      `CHK(flag_clear_allow, 1'b1)
      bus(1'b1, 8'h10, 32'h0);
      `CHK(flag_clear_allow, 1'b0)
      @(posedge clk_sys);
      rti_exec <= 1'b1;
      @(posedge clk_sys);
      rti_exec <= 1'b0;
      repeat (2) @(posedge clk_sys);
      `CHK(flag_clear_allow, 1'b1)
      $display("Break test done");
      boundary(3'h2);
      `CHK(last_clr, 1'b1)
      `CHK({cpu_clk_en, periph_clk_en}, 2'h1)
      @(posedge clk_sys);
      irq_req <= 20'h00020;
      @(posedge clk_sys);
      #1 `CHK(vector_sel, 5'h06)
      irq_req <= 20'h00000;
      wait_req(1'b0, 40);
      @(posedge clk_sys);
      emul_mode <= 1'b1;
      boundary(3'h2);
      @(posedge clk_sys);
      break_req <= 1'b1;
      #1 wait_req(1'b1, 4);
      @(posedge clk_sys);
      break_req <= 1'b0;
      `CHK(vector_sel, 5'h00)
      wait_req(1'b0, 40);
      bus(1'b0, 8'h0C, 32'h0);
      `CHK(rd[1], 1'b1)
      $display("Wait test done");
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         sso <= i[0];
         boundary(3'h1);
         `CHK(last_clr, 1'b1)
         `CHK({cpu_clk_en, periph_clk_en}, 2'h0)
         @(posedge clk_sys);
         irq_req <= 20'h00004;
         #1 wait_req(1'b1, NL + 10);
         `CHK(n >= (i ? NS : NL) && n <= (i ? NS : NL) + 4, 1'b1)
         irq_req <= 20'h00000;
         wait_req(1'b0, 40);
      end
      $display("Stop test done");
      @(posedge clk_sys);
      irq_req <= 20'h00002;
      boundary(3'h0);
      reset_req <= 1'b1;
      @(posedge clk_sys);
      reset_req <= 1'b0;
      irq_req <= 20'h00000;
      #1 `CHK(int_request, 1'b0)
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         wdo <= i[0];
         @(posedge clk_sys);
         #1 `CHK(watchdog_enable, ~i[0])
      end
      $display("Reset test done");
      finish_test();
   end
endmodule
